// >>> dv/cfg_host.sv
// Purpose: Host model making configuration accesses.
// Assumes: Drives at falling edges; one access at a time.
// Notes: Global bits are reached only through functions 0 and 1.
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
	input wire logic i_clk, // Bus clock.
	input wire sysctl_pkg::cfg_rsp_t i_rsp, // Answer.
	output var sysctl_pkg::cfg_req_t o_req // Request.
);
	import sysctl_pkg::*;
	initial o_req = '0;
	// Request for one cycle; the answer is taken in the next one.
	task acc(input logic w, input logic [2:0] f, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(negedge i_clk);
		o_req = {1'b1, w, f, a, 4'hf, d};
		@(negedge i_clk);
		o_req = '0;
		r = i_rsp.ack ? i_rsp.rdata : 32'hdead_beef;
	endtask
endmodule
`default_nettype wire

// >>> dv/sysctl_checker.sv
// Purpose: Port-level assertions for the system control register bank.
// Assumes: One clock; i_resetn is the global reset.
// Notes: Bound into the design from the bench top.
`timescale 1ns/1ps
`default_nettype none
module sysctl_checker (
	input wire logic i_clk, // Clock.
	input wire logic i_resetn, // Global reset.
	input wire sysctl_pkg::cfg_req_t i_cfg, // Request.
	input wire sysctl_pkg::cfg_rsp_t o_cfg, // Answer.
	input wire logic o_switch_clk_oe, // Clock drive enable.
	input wire logic [1:0] i_sock_pwr_wr, // Power writes.
	input wire logic o_smi_irq, // SMI request.
	input wire logic o_legacy_interrupt_line_two_pulse, // Line two pulse.
	input wire logic [1:0] o_csc_pulse // Status change pulse.
);
	import sysctl_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// Decoded writes of the top byte and accesses to mapped words.
	wire logic sc_wr = i_cfg.req && i_cfg.write && i_cfg.be[3] &&
		i_cfg.offset == 8'h80 && i_cfg.func < 3'h2;
	wire logic mapped = i_cfg.offset == 8'h80 || i_cfg.offset == 8'h44;
	property p_ack; i_cfg.req |=> o_cfg.ack; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_idle; !i_cfg.req |=> !o_cfg.ack; endproperty
	a_idle: assert property (p_idle) else $error("stray ack");
	property p_unmap; i_cfg.req && !mapped |=> o_cfg.rdata == '0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped data");
	property p_oe; sc_wr |=> o_switch_clk_oe == $past(i_cfg.wdata[27]);
	endproperty
	a_oe: assert property (p_oe) else $error("clock select");
	property p_csc; |o_csc_pulse |-> o_csc_pulse == $past(i_sock_pwr_wr);
	endproperty
	a_csc: assert property (p_csc) else $error("csc socket");
	property p_legacy_interrupt_line_two; o_legacy_interrupt_line_two_pulse |-> $past(|i_sock_pwr_wr); endproperty
	a_legacy_interrupt_line_two: assert property (p_legacy_interrupt_line_two) else $error("legacy_interrupt_line_two cause");
	property p_smi; o_legacy_interrupt_line_two_pulse |=> o_smi_irq; endproperty
	a_smi: assert property (p_smi) else $error("smi missing");
	property p_hold; o_smi_irq && !i_cfg.req && $past(!i_cfg.req) |=>
		o_smi_irq; endproperty
	a_hold: assert property (p_hold) else $error("smi dropped");
	c_legacy_interrupt_line_two: cover property (o_legacy_interrupt_line_two_pulse);
	c_csc: cover property (|o_csc_pulse);
	c_oe: cover property ($rose(o_switch_clk_oe));
endmodule
`default_nettype wire

// >>> dv/system_interrupt_control_register_tb_top.sv
// Purpose: Self-checking bench for the system control register bank.
// Assumes: Inputs change at falling edges.
// Notes: The host model makes every configuration access.
`timescale 1ns/1ps
`default_nettype none
module system_interrupt_control_register_tb_top;
	import sysctl_pkg::*;
	logic i_clk = 0, i_resetn = 0, i_pci_resetn = 1, i_switch_clk = 0;
	logic [2:0] i_func_int = '0;
	logic [1:0] i_sock_pwr_wr = '0, o_csc_pulse;
	cfg_req_t i_cfg;
	cfg_rsp_t o_cfg;
	int_pin_t o_int_pin;
	logic [3:0] o_serial_slots;
	logic o_switch_clk, o_switch_clk_oe, o_switch_clk_tick;
	logic o_smi_irq, o_legacy_interrupt_line_two_pulse;
	logic [31:0] rd;
	logic [3:0] slot [4] = '{4'h1, 4'h2, 4'h2, 4'h8};
	int bad_count = 0, checked = 0, cyc = 0;
	int ticks = 0, flips = 0;
	logic sw_prev = 0;
	system_interrupt_control_register uut (.i_clk, .i_resetn,
		.i_pci_resetn, .i_cfg, .o_cfg, .i_func_int, .o_serial_slots,
		.o_int_pin, .i_switch_clk, .o_switch_clk, .o_switch_clk_oe,
		.o_switch_clk_tick, .i_sock_pwr_wr, .o_smi_irq, .o_legacy_interrupt_line_two_pulse,
		.o_csc_pulse);
	cfg_host host (.i_clk, .i_rsp(o_cfg), .o_req(i_cfg));
	// Clock, external switch clock and a hang limit.
	initial forever #20 i_clk = ~i_clk;
	always #160 i_switch_clk = ~i_switch_clk;
	always @(posedge i_clk) if (++cyc > 3000) begin
		bad_count++;
		close_out();
	end
	// Count clock ticks and derived clock changes as the design sees them.
	always @(posedge i_clk) begin
		if (o_switch_clk_tick) ticks <= ticks + 1;
		if (o_switch_clk != sw_prev) flips <= flips + 1;
		sw_prev <= o_switch_clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Ticks and derived clock changes over sixteen PCI clocks.
	task sw_count(input int want_ticks);
		int t0, f0;
		t0 = ticks;
		f0 = flips;
		repeat (16) @(negedge i_clk);
		chk(ticks - t0, want_ticks);
		chk(flips - f0, 4);
	endtask
	task pulse(input logic [1:0] s);
		i_sock_pwr_wr = s;
		@(negedge i_clk);
		i_sock_pwr_wr = 2'h0;
	endtask
	// Reset values, unmapped place and slot stepping codes.
	task t_regs;
		host.acc(0, 0, 8'h80, '0, rd);
		chk(rd, 32'h0044_9060);
		host.acc(0, 1, 8'h44, '0, rd);
		chk(rd, 32'h0000_0001);
		host.acc(0, 0, 8'h40, '0, rd);
		chk(rd, '0);
		chk(o_int_pin, 24'h03_0201);
		i_func_int = 3'h1;
		for (int s = 0; s < 4; s++) begin
			host.acc(1, 0, 8'h80, {s[1:0], 30'h0044_9060}, rd);
			@(negedge i_clk);
			chk(o_serial_slots, slot[s]);
		end
		$display("regs test done");
	endtask
	// Pair tie then tie of all three interrupts.
	task t_tie;
		host.acc(1, 0, 8'h80, 32'h2044_9060, rd);
		i_func_int = 3'h2;
		repeat (2) @(negedge i_clk);
		chk(o_serial_slots, 4'h1);
		chk(o_int_pin.func1, 8'h01);
		host.acc(1, 1, 8'h80, 32'h1044_9060, rd);
		i_func_int = 3'h4;
		repeat (2) @(negedge i_clk);
		chk(o_serial_slots, 4'h1);
		chk(o_int_pin.func2, 8'h01);
		$display("tie test done");
	endtask
	// Switch clock select and the PCI reset sparing global bits.
	task t_clk;
		host.acc(1, 1, 8'h80, 32'hc844_9060, rd);
		host.acc(1, 0, 8'h44, 32'h0000_ffff, rd);
		host.acc(0, 0, 8'h44, '0, rd);
		chk(rd, 32'h0000_ffff);
		chk(o_switch_clk_oe, 1);
		sw_count(2);
		repeat (20) @(negedge i_clk);
		i_pci_resetn = 0;
		@(negedge i_clk);
		i_pci_resetn = 1;
		host.acc(0, 0, 8'h80, '0, rd);
		chk(rd, 32'hc044_9060);
		host.acc(0, 0, 8'h44, '0, rd);
		chk(rd, 32'h0000_0001);
		chk(o_switch_clk_oe, 0);
		sw_count(2);
		$display("clock test done");
	endtask
	// Power writes with both routes, flag set and cleared by writing one.
	task t_smi;
		pulse(2'h1);
		chk({o_legacy_interrupt_line_two_pulse, o_csc_pulse}, 3'h0);
		host.acc(0, 0, 8'h80, '0, rd);
		chk(rd, 32'hc044_9060);
		host.acc(1, 0, 8'h80, 32'h0144_9060, rd);
		pulse(2'h1);
		chk(o_legacy_interrupt_line_two_pulse, 1);
		@(negedge i_clk);
		chk(o_smi_irq, 1);
		host.acc(0, 0, 8'h80, '0, rd);
		chk(rd, 32'h0344_9060);
		host.acc(1, 0, 8'h80, 32'h0744_9060, rd);
		@(negedge i_clk);
		chk(o_smi_irq, 0);
		pulse(2'h2);
		chk({o_legacy_interrupt_line_two_pulse, o_csc_pulse}, 3'h2);
		host.acc(0, 1, 8'h80, '0, rd);
		chk(rd, 32'h0744_9060);
		host.acc(1, 1, 8'h80, 32'h0744_9060, rd);
		@(negedge i_clk);
		chk(o_smi_irq, 0);
		$display("smi test done");
	endtask
	initial begin
		repeat (20) @(negedge i_clk);
		i_resetn = 1;
		t_regs();
		t_tie();
		t_clk();
		t_smi();
		close_out();
	end
endmodule
bind system_interrupt_control_register sysctl_checker chk_i (.i_clk,
	.i_resetn, .i_cfg, .o_cfg, .o_switch_clk_oe, .i_sock_pwr_wr,
	.o_smi_irq, .o_legacy_interrupt_line_two_pulse, .o_csc_pulse);
`default_nettype wire

// >>> logic/system_interrupt_control_register.sv
// Purpose: System control and legacy base registers of a dual-socket card
//          controller, with interrupt slot steering, ties, switch clock
//          select and SMI signalling on socket power writes.
// Assumes: Configuration requests are synchronous to i_clk.
// Notes:   i_resetn is the global reset; i_pci_resetn is the PCI reset.
// Function
// (RL1) Stepping field selects which serial slots carry the three interrupts.
// (RL2) Pair tie merges the second interrupt onto the first and reports it.
// (RL3) Tie all merges every interrupt onto the first and reports it.
// (RL4) Clock select: zero takes the external switch clock, one drives it.
// (RL5) Route bit sends power write events to line two or card status.
// (RL6) SMI flag sets on power writes when enabled; writing one clears.
// (RL7) While SMI enable is set each socket power write raises SMI.
// (RL8) Global bits clear only on global reset, not on PCI reset.
// (RL9) Host reaches the global bits only through functions zero and one.
// (RL10) Legacy base register at its offset in both functions, reset one.
// (RL11) SMI request stays high until the flag clears, then drops next clock.
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defs.svh"

module system_interrupt_control_register (
	input wire logic i_clk, // PCI clock, 25 MHz.
	input wire logic i_resetn, // Global reset, asynchronous, active low.
	input wire logic i_pci_resetn, // PCI reset, synchronous, active low.
	input wire sysctl_pkg::cfg_req_t i_cfg, // Configuration request.
	output sysctl_pkg::cfg_rsp_t o_cfg, // Configuration answer.
	input wire logic [2:0] i_func_int, // Function interrupts A, B, C.
	output logic [3:0] o_serial_slots, // Serial frame slots A to D.
	output sysctl_pkg::int_pin_t o_int_pin, // Interrupt pin reports.
	input wire logic i_switch_clk, // Switch clock pin input.
	output logic o_switch_clk, // Switch clock pin output.
	output logic o_switch_clk_oe, // Switch clock pin drive enable.
	output logic o_switch_clk_tick, // Rising edge of selected clock.
	input wire logic [1:0] i_sock_pwr_wr, // Socket power write pulses.
	output logic o_smi_irq, // SMI request level.
	output logic o_legacy_interrupt_line_two_pulse, // Legacy line two event pulse.
	output logic [1:0] o_csc_pulse // Card status change pulse per socket.
);
	import sysctl_pkg::*;

	logic [1:0] step_q;
	logic pair_tie_q;
	logic all_tie_q;
	logic route_q;
	logic smi_en_q;
	logic [1:0] smi_flag_q;
	logic [1:0] smi_flag_d;
	logic clk_sel_q;
	logic [22:0] low_q;
	logic [31:0] legacy_q;
	cfg_rsp_t rsp_q;
	logic smi_irq_q;
	logic legacy_interrupt_line_two_q;
	logic [1:0] csc_q;
	logic [7:0] div_q;
	logic sw_clk_q;
	logic ext_q;
	logic [3:0] slots_q;
	int_pin_t pin_q;

	// Merge write data into a register under byte enables and a mask.
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] be,
			input logic [31:0] wmask);
		logic [31:0] lanes;
		lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		merge = (old & ~(lanes & wmask)) | (wd & lanes & wmask);
	endfunction

	// Access decode; only functions zero and one own these registers.
	wire func_ok = (i_cfg.func == `FUNC_SOCKET0) ||
		(i_cfg.func == `FUNC_SOCKET1); // RL9
	wire hit_sc = i_cfg.req && func_ok && (i_cfg.offset == `OFS_SYS_CTRL);
	wire hit_lb = i_cfg.req && func_ok &&
		(i_cfg.offset == `OFS_LEGACY_BASE); // RL10
	wire wr_sc = hit_sc && i_cfg.write;
	wire wr_top = wr_sc && i_cfg.be[`BE_TOP];
	wire wr_lb = hit_lb && i_cfg.write;
	wire sock = i_cfg.func[0];
	wire [31:0] wd = i_cfg.wdata;

	// Read value of the system control word for the addressed socket.
	wire [31:0] sc_read = {step_q, pair_tie_q, all_tie_q, clk_sel_q,
		route_q, smi_flag_q[sock], smi_en_q, 1'b0, low_q};
	wire [31:0] rd_mux = hit_sc ? sc_read :
		(hit_lb ? legacy_q : 32'h0000_0000);
	wire [31:0] lb_next = merge(legacy_q, wd, i_cfg.be, `LEGACY_BASE_WMASK);
	wire [31:0] low_next = merge({9'h000, low_q}, wd, i_cfg.be,
		{9'h000, `SYS_LOW_WMASK});

	// Power write events while SMI is enabled; set wins over clear.
	wire [1:0] smi_evt = i_sock_pwr_wr & {2{smi_en_q}}; // RL7
	wire [1:0] clr_sel = {sock, ~sock};
	wire [1:0] smi_clr = {2{wr_top && wd[`SC_SMI_FLAG]}} & clr_sel;
	assign smi_flag_d = smi_evt | (smi_flag_q & ~smi_clr); // RL6

	// Interrupt ties ahead of slot steering.
	wire int_a = all_tie_q ? |i_func_int :
		(pair_tie_q ? (i_func_int[0] | i_func_int[1]) : i_func_int[0]);
	wire int_b = (pair_tie_q || all_tie_q) ? 1'b0 : i_func_int[1]; // RL2
	wire int_c = all_tie_q ? 1'b0 : i_func_int[2]; // RL3
	wire [3:0] slots_d = (step_q == 2'b00) ? {1'b0, int_c, int_b, int_a} :
		(step_q == 2'b11) ? {int_a, 1'b0, int_c, int_b} :
		{int_c, int_b, int_a, 1'b0}; // RL1
	wire [7:0] pin_f1 = (pair_tie_q || all_tie_q) ? `PIN_INTA : `PIN_INTB;
	wire [7:0] pin_f2 = all_tie_q ? `PIN_INTA : `PIN_INTC;

	// Switch clock divider and selected clock edge.
	wire div_end = (div_q == (`SW_CLK_HALF - `SW_CLK_ONE));
	wire sel_clk = clk_sel_q ? sw_clk_q : i_switch_clk; // RL4

	// Global bits: cleared by global reset only.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin // RL8
			step_q <= 2'(`SYS_CTRL_RESET >> `SC_STEP_LO);
			pair_tie_q <= 1'(`SYS_CTRL_RESET >> `SC_PAIR_TIE);
			all_tie_q <= 1'(`SYS_CTRL_RESET >> `SC_ALL_TIE);
			route_q <= 1'(`SYS_CTRL_RESET >> `SC_SMI_ROUTE);
			smi_en_q <= 1'(`SYS_CTRL_RESET >> `SC_SMI_EN);
			smi_flag_q <= 2'b00;
			low_q <= 23'(`SYS_CTRL_RESET);
		end else begin
			smi_flag_q <= smi_flag_d;
			if (wr_top) begin
				step_q <= wd[`SC_STEP_HI:`SC_STEP_LO];
				pair_tie_q <= wd[`SC_PAIR_TIE];
				all_tie_q <= wd[`SC_ALL_TIE];
				route_q <= wd[`SC_SMI_ROUTE];
				smi_en_q <= wd[`SC_SMI_EN];
			end
			if (wr_sc) begin
				low_q <= low_next[`SC_LOW_HI:0];
			end
		end
	end

	// Bits cleared by either reset: clock select and legacy base.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			clk_sel_q <= 1'b0;
			legacy_q <= `LEGACY_BASE_RESET;
		end else if (!i_pci_resetn) begin
			clk_sel_q <= 1'b0;
			legacy_q <= `LEGACY_BASE_RESET; // RL10
		end else begin
			if (wr_top) begin
				clk_sel_q <= wd[`SC_CLK_SEL]; // RL4
			end
			if (wr_lb) begin
				legacy_q <= lb_next;
			end
		end
	end

	// Configuration answer one cycle after each request.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rsp_q <= '0;
		end else begin
			rsp_q.ack <= i_cfg.req;
			rsp_q.rdata <= (i_cfg.req && !i_cfg.write) ? rd_mux : 32'h0000_0000;
		end
	end

	// SMI request and routed event pulses.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			smi_irq_q <= 1'b0;
			legacy_interrupt_line_two_q <= 1'b0;
			csc_q <= 2'b00;
		end else begin
			smi_irq_q <= |smi_flag_q; // RL11
			legacy_interrupt_line_two_q <= |smi_evt && !route_q; // RL5
			csc_q <= smi_evt & {2{route_q}}; // RL5
		end
	end

	// Serial slots and pin reports.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			slots_q <= 4'h0;
			pin_q <= {`PIN_INTC, `PIN_INTB, `PIN_INTA};
		end else begin
			slots_q <= slots_d;
			pin_q <= {pin_f2, pin_f1, `PIN_INTA};
		end
	end

	// Switch clock generation from the PCI clock and edge detection.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			div_q <= `SW_CLK_ZERO;
			sw_clk_q <= 1'b0;
			ext_q <= 1'b0;
		end else begin
			div_q <= div_end ? `SW_CLK_ZERO : 8'(div_q + `SW_CLK_ONE);
			if (div_end) begin
				sw_clk_q <= ~sw_clk_q;
			end
			ext_q <= sel_clk;
		end
	end

	assign o_cfg = rsp_q;
	assign o_serial_slots = slots_q;
	assign o_int_pin = pin_q;
	assign o_switch_clk = sw_clk_q;
	assign o_switch_clk_oe = clk_sel_q; // RL4
	assign o_switch_clk_tick = sel_clk && !ext_q;
	assign o_smi_irq = smi_irq_q;
	assign o_legacy_interrupt_line_two_pulse = legacy_interrupt_line_two_q;
	assign o_csc_pulse = csc_q;

endmodule
`default_nettype wire

// >>> shared/sysctl_defs.svh
// Purpose: Offsets, field positions, reset values and counts for the
//          system control register bank.
// Assumes: Configuration offsets are byte addresses of aligned words.
// Notes:   Definitions only.
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH

// Configuration offsets.
`define OFS_LEGACY_BASE 8'h44
`define OFS_SYS_CTRL 8'h80

// Functions that own the global bits.
`define FUNC_SOCKET0 3'h0
`define FUNC_SOCKET1 3'h1

// Reset values.
`define LEGACY_BASE_RESET 32'h0000_0001
`define SYS_CTRL_RESET 32'h0844_9060

// Writable bits of the legacy base and of the low system control bits.
`define LEGACY_BASE_WMASK 32'h0000_FFFE
`define SYS_LOW_WMASK 23'h7F_C07B

// Field positions of the system control register.
`define SC_STEP_HI 31
`define SC_STEP_LO 30
`define SC_PAIR_TIE 29
`define SC_ALL_TIE 28
`define SC_CLK_SEL 27
`define SC_SMI_ROUTE 26
`define SC_SMI_FLAG 25
`define SC_SMI_EN 24
`define SC_LOW_HI 22

// Byte lane that carries bits 31..24.
`define BE_TOP 3

// Interrupt pin codes reported per function.
`define PIN_INTA 8'h01
`define PIN_INTB 8'h02
`define PIN_INTC 8'h03

// Half period of the derived switch clock, in PCI clock cycles.
`define SW_CLK_HALF 8'd4
`define SW_CLK_ZERO 8'd0
`define SW_CLK_ONE 8'd1

`endif

// >>> shared/sysctl_pkg.sv
// Purpose: Types shared by the system control register bank.
// Assumes: One configuration access in flight at a time.
// Notes:   Constants live in the defs header.
`default_nettype none
package sysctl_pkg;

	// Configuration access request.
	typedef struct packed {
		logic req;
		logic write;
		logic [2:0] func;
		logic [7:0] offset;
		logic [3:0] be;
		logic [31:0] wdata;
	} cfg_req_t;

	// Configuration access answer.
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} cfg_rsp_t;

	// Interrupt pin register value for functions 0, 1 and 2.
	typedef struct packed {
		logic [7:0] func2;
		logic [7:0] func1;
		logic [7:0] func0;
	} int_pin_t;

endpackage
`default_nettype wire
